// File: hw/aof_defs.svh
`ifndef AOF_DEFS_SVH
`define AOF_DEFS_SVH
`define AOF_SN_TAG 8'h90
`define AOF_SN_LEN 8'h02
`define AOF_LEN_ONE 8'h81
`define AOF_LEN_TWO 8'h82
`define AOF_SHORT_LIM 16'h0080
`define AOF_BYTE_LIM 16'h0100
`define AOF_CLASS_MAX 16'hbffe
`define AOF_KIND_PRIV 2'h3
`define AOF_I0 2'h0
`define AOF_I1 2'h1
`define AOF_I2 2'h2
`define AOF_I3 2'h3
`endif

// File: hw/aof_pkg.sv
`include "aof_defs.svh"
package aof_pkg;
  typedef logic [31:0] aof_rid_t;
  typedef enum logic [2:0] {TX_IDLE, TX_SHDR, TX_TAG, TX_LEN, TX_BODY} aof_tx_st_t;
  typedef enum logic [2:0] {
    RX_STAG, RX_SLEN, RX_SN, RX_OTAG, RX_LEN0, RX_LENX, RX_BODY, RX_SKIP
  } aof_rx_st_t;
  typedef struct packed {
    aof_tx_st_t st;
    logic [1:0] idx;
    logic [23:0] tag;
    logic [23:0] mtag;
    logic chain;
    logic more;
    logic [15:0] sn;
    logic [15:0] rem;
    logic [15:0] blk;
    logic [15:0] bcnt;
    logic vld;
    logic [7:0] dat;
    logic lst;
    logic brdy;
    logic busy;
    aof_rid_t rid;
    logic rid_bad;
    aof_rid_t best;
    logic found;
  } aof_tx_state_t;
  typedef struct packed {
    aof_rx_st_t st;
    logic [1:0] idx;
    logic [1:0] nlen;
    logic [15:0] sn;
    logic [23:0] tag;
    logic [15:0] len;
    logic [15:0] bcnt;
    logic [15:0] tot;
    logic chain;
    logic rdy;
    logic bv;
    logic [7:0] bb;
    logic done;
    logic [23:0] dtag;
    logic [15:0] dlen;
    logic err;
    logic [1:0] kind;
    logic priv;
    logic [15:0] cls;
    logic [9:0] typ;
    logic [5:0] ver;
    logic [9:0] def;
    logic [19:0] ident;
    logic rbad;
  } aof_rx_state_t;
  // Reserved or out-of-range identifier check shared by both ends.
  function automatic logic aof_rid_bad(input aof_rid_t rid);
    if (rid[31:30] == `AOF_KIND_PRIV) begin
      return &rid[19:0];
    end
    return (rid[31:16] == 16'h0000) || (rid[31:16] > `AOF_CLASS_MAX) ||
      (&rid[29:16]) || (&rid[15:6]) || (&rid[5:0]);
  endfunction
endpackage

// File: hw/aof_link_if.sv
interface aof_link_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  logic last;
  modport dev (output valid, output data, output last, input ready);
  modport hst (input valid, input data, input last, output ready);
endinterface

// File: hw/aof_dev_end.sv
`include "aof_defs.svh"
module aof_dev_end #(
  parameter logic [15:0] MAX_BLOCK = 16'h0100
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Link
  aof_link_if.dev link,
  // Object request
  input wire logic i_obj_start,
  input wire logic [23:0] i_obj_tag,
  input wire logic [23:0] i_more_tag,
  input wire logic i_chain_en,
  input wire logic [15:0] i_obj_len,
  input wire logic [15:0] i_obj_session,
  output logic o_busy,
  // Body bytes
  input wire logic i_body_valid,
  input wire logic [7:0] i_body_byte,
  output logic o_body_ready,
  // Identifier encoder
  input wire logic [1:0] i_rid_kind,
  input wire logic [13:0] i_rid_class,
  input wire logic [9:0] i_rid_type,
  input wire logic [5:0] i_rid_ver,
  input wire logic [9:0] i_rid_definer,
  input wire logic [19:0] i_rid_identity,
  output aof_pkg::aof_rid_t o_rid,
  output logic o_rid_bad,
  // Latest-version selector
  input wire logic i_sel_clear,
  input wire logic i_sel_valid,
  input wire aof_pkg::aof_rid_t i_sel_rid,
  input wire logic [25:0] i_sel_want,
  output aof_pkg::aof_rid_t o_sel_rid,
  output logic o_sel_found
);
  import aof_pkg::*;
  aof_tx_state_t s;
  aof_tx_state_t n;
  always_comb begin
    logic fin;
    logic hend;
    logic [23:0] ctag;
    aof_rid_t enc;
    fin = 1'b0;
    hend = 1'b0;
    enc = 32'h0000_0000;
    n = s;
    ctag = s.more ? s.mtag : s.tag;
    if (s.vld && link.ready) begin
      n.vld = 1'b0;
      n.lst = 1'b0;
    end
    case (s.st)
      TX_IDLE: begin
        if (i_obj_start) begin
          n.tag = i_obj_tag;
          n.mtag = i_more_tag;
          n.chain = i_chain_en;
          n.rem = i_obj_len;
          n.sn = i_obj_session;
          n.idx = `AOF_I0;
          n.busy = 1'b1;
          n.st = TX_SHDR;
        end
      end
      TX_SHDR: begin
        if (!n.vld) begin
          n.vld = 1'b1;
          n.idx = s.idx + `AOF_I1;
          case (s.idx)
            `AOF_I0: n.dat = `AOF_SN_TAG;
            `AOF_I1: n.dat = `AOF_SN_LEN;
            `AOF_I2: n.dat = s.sn[15:8];
            default: begin
              n.dat = s.sn[7:0];
              n.idx = `AOF_I0;
              n.st = TX_TAG;
              if (s.chain && s.rem > MAX_BLOCK) begin
                n.blk = MAX_BLOCK;
                n.more = 1'b1;
              end else begin
                n.blk = s.rem;
                n.more = 1'b0;
              end
            end
          endcase
        end
      end
      TX_TAG: begin
        if (!n.vld) begin
          n.vld = 1'b1;
          n.idx = s.idx + `AOF_I1;
          case (s.idx)
            `AOF_I0: n.dat = ctag[23:16];
            `AOF_I1: n.dat = ctag[15:8];
            default: begin
              n.dat = ctag[7:0];
              n.idx = `AOF_I0;
              n.st = TX_LEN;
            end
          endcase
        end
      end
      TX_LEN: begin
        if (!n.vld) begin
          n.vld = 1'b1;
          n.idx = s.idx + `AOF_I1;
          if (s.blk < `AOF_SHORT_LIM) begin
            n.dat = s.blk[7:0];
            hend = 1'b1;
          end else if (s.blk < `AOF_BYTE_LIM) begin
            n.dat = (s.idx == `AOF_I0) ? `AOF_LEN_ONE : s.blk[7:0];
            hend = (s.idx != `AOF_I0);
          end else begin
            case (s.idx)
              `AOF_I0: n.dat = `AOF_LEN_TWO;
              `AOF_I1: n.dat = s.blk[15:8];
              default: begin
                n.dat = s.blk[7:0];
                hend = 1'b1;
              end
            endcase
          end
          if (hend) begin
            fin = (s.blk == 16'h0000);
            n.bcnt = s.blk;
            n.st = TX_BODY;
          end
        end
      end
      TX_BODY: begin
        if (s.brdy && i_body_valid) begin
          n.vld = 1'b1;
          n.dat = i_body_byte;
          n.bcnt = s.bcnt - 16'h0001;
          fin = (s.bcnt == 16'h0001);
        end
      end
      default: n.st = TX_IDLE;
    endcase
    // Every block closes its own session unit, so a chained object longer than MAX_BLOCK is split across several units.
    if (fin) begin
      n.lst = 1'b1;
      n.rem = s.rem - s.blk;
      n.idx = `AOF_I0;
      n.st = (n.rem == 16'h0000) ? TX_IDLE : TX_SHDR;
      n.busy = (n.rem != 16'h0000);
    end
    n.brdy = (n.st == TX_BODY) && !n.vld;
    // A reserved identifier is replaced by zero and flagged, never emitted.
    if (i_rid_kind == `AOF_KIND_PRIV) begin
      enc = {i_rid_kind, i_rid_definer, i_rid_identity};
    end else begin
      enc = {i_rid_kind, i_rid_class, i_rid_type, i_rid_ver};
    end
    n.rid_bad = aof_rid_bad(enc);
    n.rid = n.rid_bad ? 32'h0000_0000 : enc;
    if (i_sel_clear) begin
      n.found = 1'b0;
      n.best = 32'h0000_0000;
    end else if (i_sel_valid && i_sel_rid[31:6] == i_sel_want &&
        i_sel_rid[31:30] != `AOF_KIND_PRIV && !aof_rid_bad(i_sel_rid) &&
        (!s.found || i_sel_rid[5:0] > s.best[5:0])) begin
      n.found = 1'b1;
      n.best = i_sel_rid;
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign link.valid = s.vld;
  assign link.data = s.dat;
  assign link.last = s.lst;
  assign o_busy = s.busy;
  assign o_body_ready = s.brdy;
  assign o_rid = s.rid;
  assign o_rid_bad = s.rid_bad;
  assign o_sel_rid = s.best;
  assign o_sel_found = s.found;
endmodule

// File: hw/aof_host_end.sv
`include "aof_defs.svh"
module aof_host_end (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Link
  aof_link_if.hst link,
  // Chained tag pair
  input wire logic [23:0] i_more_tag,
  input wire logic [23:0] i_last_tag,
  // Received objects
  output logic [15:0] o_session_index,
  output logic o_body_valid,
  output logic [7:0] o_body_byte,
  output logic o_obj_done,
  output logic [23:0] o_obj_tag,
  output logic [15:0] o_obj_len,
  output logic o_chain_open,
  output logic o_err,
  // Identifier decoder
  input wire aof_pkg::aof_rid_t i_rid,
  output logic [1:0] o_identifier_kind,
  output logic o_rid_private,
  output logic [15:0] o_rid_class,
  output logic [9:0] o_rid_type,
  output logic [5:0] o_rid_ver,
  output logic [9:0] o_rid_definer,
  output logic [19:0] o_rid_identity,
  output logic o_rid_reserved
);
  import aof_pkg::*;
  aof_rx_state_t s;
  aof_rx_state_t n;
  always_comb begin
    logic take;
    logic hend;
    logic oend;
    logic bad;
    logic [15:0] tot;
    take = link.valid && s.rdy;
    hend = 1'b0;
    oend = 1'b0;
    bad = 1'b0;
    tot = s.tot;
    n = s;
    n.rdy = 1'b1;
    n.bv = 1'b0;
    n.done = 1'b0;
    n.err = 1'b0;
    if (take) begin
      n.idx = s.idx + `AOF_I1;
      case (s.st)
        RX_STAG: begin
          if (link.data == `AOF_SN_TAG) begin
            n.st = RX_SLEN;
          end else begin
            bad = 1'b1;
          end
        end
        RX_SLEN: begin
          n.idx = `AOF_I0;
          if (link.data == `AOF_SN_LEN) begin
            n.st = RX_SN;
          end else begin
            bad = 1'b1;
          end
        end
        RX_SN: begin
          // The high byte waits in the length field so the old index stays comparable.
          n.len = {8'h00, link.data};
          if (s.idx == `AOF_I1) begin
            n.sn = {s.len[7:0], link.data};
            n.idx = `AOF_I0;
            n.st = RX_OTAG;
            // A chain that jumps session cannot be joined into one body.
            if (s.chain && n.sn != s.sn) begin
              bad = 1'b1;
            end
          end
        end
        RX_OTAG: begin
          n.tag = {s.tag[15:0], link.data};
          if (s.idx == `AOF_I2) begin
            n.st = RX_LEN0;
          end
        end
        RX_LEN0: begin
          if (!link.data[7]) begin
            n.len = {8'h00, link.data};
            hend = 1'b1;
          end else if (link.data == `AOF_LEN_ONE || link.data == `AOF_LEN_TWO) begin
            n.len = 16'h0000;
            n.nlen = link.data[1:0];
            n.st = RX_LENX;
          end else begin
            // Lengths wider than sixteen bits are not carried.
            bad = 1'b1;
          end
        end
        RX_LENX: begin
          n.len = {s.len[7:0], link.data};
          n.nlen = s.nlen - `AOF_I1;
          hend = (s.nlen == `AOF_I1);
        end
        RX_BODY: begin
          n.bv = 1'b1;
          n.bb = link.data;
          tot = s.tot + 16'h0001;
          n.tot = tot;
          n.bcnt = s.bcnt - 16'h0001;
          oend = (s.bcnt == 16'h0001);
        end
        RX_SKIP: begin
          n.st = RX_SKIP;
        end
        default: bad = 1'b1;
      endcase
      if (hend) begin
        n.bcnt = n.len;
        n.st = RX_BODY;
        oend = (n.len == 16'h0000);
      end
      if (oend) begin
        n.idx = `AOF_I0;
        n.st = RX_OTAG;
        n.tot = tot;
        if (i_more_tag != i_last_tag && s.tag == i_more_tag) begin
          n.chain = 1'b1;
        end else begin
          // Bytes were streamed out in arrival order, so the done pulse
          // closes the concatenated body with its summed length.
          n.done = 1'b1;
          n.dtag = s.tag;
          n.dlen = tot;
          n.tot = 16'h0000;
          n.chain = 1'b0;
          bad = s.chain && s.tag != i_last_tag;
        end
      end
      // A unit must end exactly at an object end; a short unit is an error.
      if (link.last) begin
        n.idx = `AOF_I0;
        n.st = RX_STAG;
        if (!oend && s.st != RX_SKIP) begin
          bad = 1'b1;
        end
      end else if (bad) begin
        n.st = RX_SKIP;
      end
      if (bad) begin
        n.err = 1'b1;
        n.chain = 1'b0;
        n.tot = 16'h0000;
      end
    end
    n.kind = i_rid[31:30];
    n.priv = (i_rid[31:30] == `AOF_KIND_PRIV);
    n.cls = n.priv ? 16'h0000 : i_rid[31:16];
    n.typ = n.priv ? 10'h000 : i_rid[15:6];
    n.ver = n.priv ? 6'h00 : i_rid[5:0];
    n.def = n.priv ? i_rid[29:20] : 10'h000;
    n.ident = n.priv ? i_rid[19:0] : 20'h00000;
    n.rbad = aof_rid_bad(i_rid);
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign link.ready = s.rdy;
  assign o_session_index = s.sn;
  assign o_body_valid = s.bv;
  assign o_body_byte = s.bb;
  assign o_obj_done = s.done;
  assign o_obj_tag = s.dtag;
  assign o_obj_len = s.dlen;
  assign o_chain_open = s.chain;
  assign o_err = s.err;
  assign o_identifier_kind = s.kind;
  assign o_rid_private = s.priv;
  assign o_rid_class = s.cls;
  assign o_rid_type = s.typ;
  assign o_rid_ver = s.ver;
  assign o_rid_definer = s.def;
  assign o_rid_identity = s.ident;
  assign o_rid_reserved = s.rbad;
endmodule

// File: dv/aof_link_properties.sv
module aof_link_checker (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Link signals
  input wire logic valid,
  input wire logic ready,
  input wire logic [7:0] data,
  input wire logic last
);
  logic [15:0] pos_ff;
  logic [15:0] nxt_pos;
  logic [7:0] form_ff;
  logic [7:0] nxt_form;
  logic [15:0] len_ff;
  logic [15:0] nxt_len;
  logic [15:0] hdr;
  logic take;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  assign take = valid && ready;
  assign hdr = (form_ff == 8'h82) ? 16'h000a : (form_ff == 8'h81) ? 16'h0009 : 16'h0008;

  // Byte position in the unit and the decoded length, so the body end can be checked.
  always_comb begin
    nxt_pos = pos_ff;
    nxt_form = form_ff;
    nxt_len = len_ff;
    if (take) begin
      nxt_pos = last ? 16'h0000 : pos_ff + 16'h0001;
      if (pos_ff == 16'h0007) begin
        nxt_form = data;
        nxt_len = {8'h00, data};
      end
      if (pos_ff == 16'h0008 && form_ff >= 8'h81) begin
        nxt_len = {8'h00, data};
      end
      if (pos_ff == 16'h0009 && form_ff == 8'h82) begin
        nxt_len = {len_ff[7:0], data};
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pos_ff <= 16'h0000;
      form_ff <= 8'h00;
      len_ff <= 16'h0000;
    end else begin
      pos_ff <= nxt_pos;
      form_ff <= nxt_form;
      len_ff <= nxt_len;
    end
  end

  sess_tag_a: assert property (valid && pos_ff == 16'h0000 |-> data == 8'h90)
    else $error("unit does not open with the session tag");
  sess_len_a: assert property (valid && pos_ff == 16'h0001 |-> data == 8'h02)
    else $error("session header length is not two");
  hdr_whole_a: assert property (valid && last |-> pos_ff >= 16'h0007)
    else $error("unit ends inside the object header");
  len_form_a: assert property (valid && pos_ff == 16'h0007 |->
    data < 8'h80 || data == 8'h81 || data == 8'h82)
    else $error("length byte has an illegal form");
  len_short_a: assert property (valid && pos_ff == 16'h0008 && form_ff == 8'h81 |->
    data >= 8'h80)
    else $error("short length sent in long form");
  len_min_a: assert property (valid && pos_ff == 16'h0008 && form_ff == 8'h82 |->
    data != 8'h00)
    else $error("two byte length with zero high byte");
  body_count_a: assert property (take && last && pos_ff > 16'h0007 |->
    pos_ff + 16'h0001 == hdr + len_ff)
    else $error("body byte count differs from length");
  empty_body_a: assert property (take && last && pos_ff == 16'h0007 |-> data == 8'h00)
    else $error("unit ends on a nonzero length byte");
  unit_end_a: assert property (take && last |=> !(valid && last) && (!valid || data == 8'h90))
    else $error("unit not closed cleanly after its last byte");

  cover property (take && last && form_ff == 8'h82);
  cover property (take && last && form_ff == 8'h81);
  cover property (take && last && pos_ff == 16'h0007);
endmodule

// File: dv/app_object_framer_tb.sv
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module app_object_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aof_pkg::*;
  localparam logic [15:0] MAXB = 16'h0004;
  localparam logic [23:0] MT = 24'h9f8010;
  localparam logic [23:0] LT = 24'h9f8011;
  localparam logic [25:0] SW = 26'h0000c05;
  int n_mismatch = 0;
  int n_compared = 0;
  int ne = 0;
  int nd = 0;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic st = 1'b0;
  logic ch = 1'b0;
  logic bv = 1'b0;
  logic sc = 1'b0;
  logic sv = 1'b0;
  logic [7:0] bb = 8'h00;
  logic [23:0] otag = 24'h000000;
  logic [15:0] olen = 16'h0000;
  logic [15:0] osn = 16'h0000;
  logic [1:0] rk = 2'h0;
  logic [13:0] rc = 14'h0000;
  logic [9:0] rt = 10'h000;
  logic [5:0] rvr = 6'h00;
  logic [9:0] rd = 10'h000;
  logic [19:0] ri = 20'h00000;
  logic [25:0] sw = 26'h0000000;
  aof_rid_t srid = 32'h00000000;
  aof_rid_t hr = 32'h00000000;
  logic [31:0] lf = 32'h000034e9;
  logic busy, bready, rbad, self, hbv, hdone, hopen, herr, dp, dres, e_done, e_err;
  aof_rid_t erid, selr;
  logic [7:0] hbb;
  logic [23:0] htag, e_tag;
  logic [15:0] hsn, hlen, dc, e_len;
  logic [1:0] dk;
  logic [9:0] dt, ddf;
  logic [5:0] dvr;
  logic [19:0] di;
  logic [7:0] qb[$];
  logic [7:0] ub[$];
  logic [55:0] qo[$];
  logic [55:0] qu[$];
  logic [55:0] ob, eh;

  aof_link_if aof_link_if_inst ();
  aof_link_if aof_link_if_err_inst ();

  always #5 i_mclk = ~i_mclk;

  aof_dev_end #(.MAX_BLOCK(MAXB)) aof_dev_end_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .link(aof_link_if_inst), .i_obj_start(st), .i_obj_tag(otag), .i_more_tag(MT),
    .i_chain_en(ch), .i_obj_len(olen), .i_obj_session(osn), .o_busy(busy),
    .i_body_valid(bv), .i_body_byte(bb), .o_body_ready(bready), .i_rid_kind(rk),
    .i_rid_class(rc), .i_rid_type(rt), .i_rid_ver(rvr), .i_rid_definer(rd),
    .i_rid_identity(ri), .o_rid(erid), .o_rid_bad(rbad), .i_sel_clear(sc),
    .i_sel_valid(sv), .i_sel_rid(srid), .i_sel_want(sw), .o_sel_rid(selr),
    .o_sel_found(self));
  aof_host_end aof_host_end_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .link(aof_link_if_inst), .i_more_tag(MT), .i_last_tag(LT), .o_session_index(hsn),
    .o_body_valid(hbv), .o_body_byte(hbb), .o_obj_done(hdone), .o_obj_tag(htag),
    .o_obj_len(hlen), .o_chain_open(hopen), .o_err(herr), .i_rid(hr),
    .o_identifier_kind(dk), .o_rid_private(dp), .o_rid_class(dc), .o_rid_type(dt),
    .o_rid_ver(dvr), .o_rid_definer(ddf), .o_rid_identity(di), .o_rid_reserved(dres));
  // A second host faces the bench directly, so faults can be injected on its link.
  aof_host_end aof_host_end_err_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .link(aof_link_if_err_inst), .i_more_tag(MT), .i_last_tag(LT), .o_session_index(),
    .o_body_valid(), .o_body_byte(), .o_obj_done(e_done), .o_obj_tag(e_tag),
    .o_obj_len(e_len), .o_chain_open(), .o_err(e_err), .i_rid(32'h00000000),
    .o_identifier_kind(), .o_rid_private(), .o_rid_class(), .o_rid_type(), .o_rid_ver(),
    .o_rid_definer(), .o_rid_identity(), .o_rid_reserved());
  aof_link_checker aof_link_checker_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .valid(aof_link_if_inst.valid), .ready(aof_link_if_inst.ready),
    .data(aof_link_if_inst.data), .last(aof_link_if_inst.last));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic rid_case(input logic [31:0] w);
    logic p;
    logic bad;
    p = (w[31:30] == 2'h3);
    bad = p ? &w[19:0] : (w[31:16] == 16'h0000 || w[31:16] > 16'hbffe || &w[29:16] ||
      &w[15:6] || &w[5:0]);
    {rk, rc, rt, rvr} = w;
    {rd, ri} = w[29:0];
    hr = w;
    @(negedge i_mclk);
    `CHK("rid", bad ? 32'h00000000 : w, erid)
    `CHK("rid_bad", bad, rbad)
    `CHK("kind", w[31:30], dk)
    `CHK("private", p, dp)
    `CHK("class", p ? 16'h0000 : w[31:16], dc)
    `CHK("type", p ? 10'h000 : w[15:6], dt)
    `CHK("version", p ? 6'h00 : w[5:0], dvr)
    `CHK("definer", p ? w[29:20] : 10'h000, ddf)
    `CHK("identity", p ? w[19:0] : 20'h00000, di)
    `CHK("reserved", bad, dres)
  endtask

  // Blocks are noted per unit as the sender is expected to cut them.
  task automatic send_obj(input logic [15:0] n, input logic c);
    logic [15:0] r;
    logic [15:0] b;
    lf = lfsr(lf);
    otag = c ? LT : {8'h9e, lf[15:0]};
    osn = lf[31:16] | 16'h0001;
    olen = n;
    ch = c;
    st = 1'b1;
    qo.push_back({otag, n, osn});
    r = n;
    do begin
      b = (c && r > MAXB) ? MAXB : r;
      r = r - b;
      qu.push_back({(r != 16'h0000) ? MT : otag, b, osn});
    end while (r != 16'h0000);
    @(negedge i_mclk);
    st = 1'b0;
    repeat (n) begin
      lf = lfsr(lf);
      bv = 1'b1;
      bb = lf[7:0];
      qb.push_back(lf[7:0]);
      for (int k = 0; k < 100 && bready !== 1'b1; k++) @(negedge i_mclk);
      @(negedge i_mclk);
    end
    bv = 1'b0;
    for (int k = 0; k < 200 && busy !== 1'b0; k++) @(negedge i_mclk);
    `CHK("busy_end", 1'b0, busy)
  endtask

  task automatic err_byte(input logic [7:0] d, input logic l);
    aof_link_if_err_inst.valid = 1'b1;
    aof_link_if_err_inst.data = d;
    aof_link_if_err_inst.last = l;
    for (int k = 0; k < 20 && aof_link_if_err_inst.ready !== 1'b1; k++) @(negedge i_mclk);
    @(negedge i_mclk);
    aof_link_if_err_inst.valid = 1'b0;
    aof_link_if_err_inst.data = ~d;
    @(negedge i_mclk);
  endtask

  // Results are sampled mid-cycle, where every flop output has settled.
  always @(negedge i_mclk) begin
    if (hbv === 1'b1) `CHK("body", qb.pop_front(), hbb)
    if (herr !== 1'b0) `CHK("err", 1'b0, herr)
    if (e_err === 1'b1) ne++;
    if (e_done === 1'b1) begin
      nd++;
      `CHK("err_len", 16'h0000, e_len)
      `CHK("err_tag", 24'h9e0001, e_tag)
    end
    if (hdone === 1'b1) begin
      ob = qo.pop_front();
      `CHK("tag", ob[55:32], htag)
      `CHK("len", ob[31:16], hlen)
      `CHK("session", ob[15:0], hsn)
      `CHK("chain_open", 1'b0, hopen)
    end
    if (aof_link_if_inst.valid === 1'b1 && aof_link_if_inst.ready === 1'b1) begin
      ub.push_back(aof_link_if_inst.data);
      if (aof_link_if_inst.last === 1'b1) begin
        ob = qu.pop_front();
        eh = {8'h90, 8'h02, ob[15:0], ob[55:32]};
        for (int k = 0; k < 7; k++) `CHK("header", eh[55 - 8 * k -: 8], ub[k])
        r_len_check(ob[31:16]);
        ub.delete();
      end
    end
  end

  task automatic r_len_check(input logic [15:0] lb);
    logic [7:0] eln;
    eln = (lb < 16'h0080) ? 8'h01 : (lb < 16'h0100) ? 8'h02 : 8'h03;
    `CHK("len_first", (eln == 8'h01) ? lb[7:0] : 8'h7f + eln, ub[7])
    `CHK("unit_size", 16'h0007 + {8'h00, eln} + lb, 16'(ub.size()))
    if (eln == 8'h03) `CHK("len_high", lb[15:8], ub[8])
    `CHK("len_low", lb[7:0], ub[6 + eln])
  endtask

  logic [31:0] rt_tab[8] = '{32'h00010041, 32'hbffe0041, 32'hbfff0041, 32'h00000041,
    32'h0002ffc1, 32'h0002007f, 32'hc00fffff, 32'hc0123456};
  logic [16:0] ob_tab[9] = '{17'h00000, 17'h00001, 17'h0007f, 17'h00080, 17'h0012c,
    17'h1000a, 17'h10004, 17'h10005, 17'h10000};
  logic [31:0] sel_tab[5] = '{{SW, 6'h03}, {SW, 6'h09}, {SW, 6'h05}, {SW, 6'h3f},
    {SW + 26'h0000001, 6'h14}};
  logic [7:0] eb[10] = '{8'h91, 8'h00, 8'h90, 8'h02, 8'h00, 8'h01, 8'h9e, 8'h00, 8'h01, 8'h00};

  initial begin
    aof_link_if_err_inst.valid = 1'b0;
    aof_link_if_err_inst.data = 8'h00;
    aof_link_if_err_inst.last = 1'b0;
    repeat (16) @(negedge i_mclk);
    i_rst_n = 1'b1;
    @(negedge i_mclk);
    foreach (rt_tab[k]) rid_case(rt_tab[k]);
    repeat (12) begin
      lf = lfsr(lf);
      rid_case(lf);
    end
    $display("identifier test done");
    sc = 1'b1;
    sw = SW;
    @(negedge i_mclk);
    sc = 1'b0;
    sv = 1'b1;
    foreach (sel_tab[k]) begin
      srid = sel_tab[k];
      @(negedge i_mclk);
    end
    sv = 1'b0;
    @(negedge i_mclk);
    `CHK("sel_rid", {SW, 6'h09}, selr)
    `CHK("sel_found", 1'b1, self)
    $display("selector test done");
    foreach (ob_tab[k]) send_obj(ob_tab[k][15:0], ob_tab[k][16]);
    repeat (4) begin
      lf = lfsr(lf);
      send_obj({10'h000, lf[5:0]}, lf[6]);
    end
    for (int k = 0; k < 400 && qo.size() != 0; k++) @(negedge i_mclk);
    `CHK("objects_left", 0, qo.size())
    $display("object test done");
    foreach (eb[k]) err_byte(eb[k], k == 1 || k == 9);
    repeat (4) @(negedge i_mclk);
    `CHK("err_count", 1, ne)
    `CHK("resync_done", 1, nd)
    $display("fault test done");
    report_and_stop();
  end

  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
